// *** tb/pss_mem_model.sv ***
// Save area memory model that stalls its write port
`timescale 1ns/1ps
`default_nettype none
module pss_mem_model (
  input  wire logic        clk_i,
  input  wire logic        wr_valid_i,
  input  wire logic [9:0]  wr_addr_i,
  input  wire logic [31:0] wr_data_i,
  output logic             wr_ready_o
);
  logic [31:0] data_q[$];
  logic [9:0]  addr_q[$];
  logic [1:0]  tick_ff;
  initial begin
    tick_ff    = 2'h0;
    wr_ready_o = 1'b0;
  end
  // Take a word at each handshake; refuse one cycle in four
  always @(posedge clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      data_q.push_back(wr_data_i);
      addr_q.push_back(wr_addr_i);
    end
    tick_ff    <= tick_ff + 2'h1;
    wr_ready_o <= (tick_ff != 2'h2);
  end
endmodule : pss_mem_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the profiling state save image block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pss_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv, swv, swr, done, bmp, fen, rdef;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, swd, head = 32'h0000_0100, filt = 32'hf000_0001;
  logic [1:0] bresp, rresp;
  logic [63:0] cb = 64'h0000_7f00_1234_5670, base = 64'h0000_7e00_0000_1000;
  logic [5:0] flg = 6'h2d;
  logic [27:0] size = 28'hfff_ffff;
  logic [255:0] rec = {8{32'ha5a5_0000}} | 256'h1234_0007;
  logic [191:0] cnt = {6{32'h8000_0001}} ^ 192'h6_0000_0005_0000_0004;
  logic sreq = 1'b0, rreq = 1'b0, rbit = 1'b0;
  logic [9:0] swa;
  int err_total = 0, checked = 0, cyc = 0;
  always #4 clk = ~clk;
  pss_save_image dut_u (.sys_clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rr), .cb_addr_i(cb), .active_flags_i(flg), .head_offset_i(head),
    .ring_base_i(base), .ring_size_i(size), .filters_i(filt), .pending_rec_i(rec),
    .counters_i(cnt), .save_req_i(sreq), .restore_req_i(rreq), .restore_bitmap_bit_i(rbit),
    .save_wr_valid_o(swv), .save_wr_ready_i(swr), .save_wr_addr_o(swa), .save_wr_data_o(swd),
    .save_done_o(done), .bitmap_bit_o(bmp), .feature_enable_o(fen), .restore_defaults_o(rdef));
  pss_mem_model mem_u (.clk_i(clk), .wr_valid_i(swv), .wr_addr_i(swa), .wr_data_i(swd),
    .wr_ready_o(swr));
  // Expected image word at index n
  function automatic logic [31:0] img(input int n);
    case (n)
      0: img = cb[31:0];
      1: img = cb[63:32];
      2: img = {25'h0, flg, 1'b0};
      3: img = head;
      4: img = base[31:0];
      5: img = base[63:32];
      6: img = {4'h0, size};
      7: img = filt;
      default: img = (n < 16) ? rec[32*(n-8)+:32] : (n < 22) ? cnt[32*(n-16)+:32] : 32'h0;
    endcase
  endfunction : img
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // AXI4-Lite write, address and data offered together
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    @(posedge clk);
    while (awv || wv || br) begin
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (br && bv) begin r = bresp; br <= 1'b0; end
      @(posedge clk);
    end
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    @(posedge clk);
    while (arv || rr) begin
      if (arv && arr) arv <= 1'b0;
      if (rr && rv) begin d = rd; r = rresp; rr <= 1'b0; end
      @(posedge clk);
    end
  endtask : axr
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(PSS_REG_ID_SIZE, d, r); chk("id size", 32'd128, d);
    chk("read resp", 32'(PSS_RESP_OKAY), 32'(r));
    axr(PSS_REG_FEAT_LO, d, r); chk("feature low", 32'h0, d);
    axr(PSS_REG_ID_OFFSET, d, r); chk("id offset", 32'd832, d);
    axr(PSS_REG_FEAT_HI, d, r); chk("feature reset", 32'h0, d);
    axr(8'h40, d, r); chk("unmapped read", {30'h0, PSS_RESP_SLVERR}, {d[29:0], r});
    axw(8'h40, 32'hffff_ffff, r); chk("unmapped write", 32'(PSS_RESP_SLVERR), 32'(r));
    axw(PSS_REG_FEAT_HI, 32'h4000_0000, r);
    chk("feature write", 32'(PSS_RESP_OKAY), 32'(r));
    axr(PSS_REG_FEAT_HI, d, r);
    chk("feature set", 32'h4000_0000, d);
    chk("feature pin", 32'h1, 32'(fen));
    $display("test regs ended");
  endtask : t_regs
  // One save; check the words written and the bitmap bit
  task t_save(input logic full);
    int n0;
    logic [31:0] d;
    logic [1:0] r;
    n0 = mem_u.data_q.size();
    sreq <= 1'b1; @(posedge clk); sreq <= 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
    chk("bitmap bit", 32'(full), 32'(bmp));
    chk("words", full ? n0 + 32 : n0, mem_u.data_q.size());
    for (int n = 0; full && n < 32; n++) begin
      chk("addr", 832 + 4 * n, 32'(mem_u.addr_q[n0+n]));
      chk("word", img(n), mem_u.data_q[n0+n]);
    end
    axr(PSS_REG_STATUS, d, r); chk("status", {29'h0, ~full, full, 1'b0}, d);
    $display("test save ended");
  endtask : t_save
  task t_restore(input logic b, input logic exp);
    logic seen;
    seen = 1'b0;
    rbit <= b; rreq <= 1'b1; @(posedge clk); rreq <= 1'b0;
    repeat (3) begin @(posedge clk); seen |= (rdef === 1'b1); end
    chk("restore defaults", 32'(exp), 32'(seen));
    $display("test restore ended");
  endtask : t_restore
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin err_total++; close_out(); end
  end
  initial begin
    logic [1:0] r0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_save(1'b1);
    cb <= 64'h0; @(posedge clk); t_save(1'b0);
    t_restore(1'b0, 1'b1);
    t_restore(1'b1, 1'b0);
    axw(PSS_REG_FEAT_HI, 32'h0, r0);
    cb <= 64'h0000_7f00_1234_5670; @(posedge clk); t_save(1'b0);
    t_restore(1'b0, 1'b0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// *** verilog/pss_image_word.sv ***
// Formatter that picks one 32-bit word of the profiling save image
`timescale 1ns/1ps
`default_nettype none
module pss_image_word
  import pss_pkg::*;
(
  input  wire logic [4:0]                     idx_i,
  input  wire logic [63:0]                    cb_addr_i,
  input  wire logic [PSS_EVENTS-1:0]          active_flags_i,
  input  wire logic [31:0]                    head_offset_i,
  input  wire logic [63:0]                    ring_base_i,
  input  wire logic [PSS_SIZE_W-1:0]          ring_size_i,
  input  wire logic [31:0]                    filters_i,
  input  wire logic [PSS_REC_W-1:0]           pending_rec_i,
  input  wire logic [PSS_EVENTS*PSS_CNT_W-1:0] counters_i,
  output logic      [31:0]                    word_o
);

  logic [2:0] rec_sel;
  logic [2:0] cnt_sel;

  // Field placement; bit 7:0 of each word is its lowest byte
  always_comb begin
    rec_sel = 3'(idx_i - PSS_W_REC_FIRST);
    cnt_sel = 3'(idx_i - PSS_W_CNT_FIRST);
    word_o  = 32'h0000_0000;                                    // R04
    if (idx_i == PSS_W_CB_LO) begin
      word_o = cb_addr_i[31:0];                                 // R05
    end else if (idx_i == PSS_W_CB_HI) begin
      word_o = cb_addr_i[63:32];                                // R05
    end else if (idx_i == PSS_W_FLAGS) begin
      word_o = {25'h0, active_flags_i, 1'b0};                   // R06 R07
    end else if (idx_i == PSS_W_HEAD) begin
      word_o = head_offset_i;                                   // R08
    end else if (idx_i == PSS_W_BASE_LO) begin
      word_o = ring_base_i[31:0];                               // R08
    end else if (idx_i == PSS_W_BASE_HI) begin
      word_o = ring_base_i[63:32];                              // R08
    end else if (idx_i == PSS_W_SIZE) begin
      word_o = {4'h0, ring_size_i};                             // R09
    end else if (idx_i == PSS_W_FILTER) begin
      word_o = filters_i;                                       // R10
    end else if (idx_i >= PSS_W_REC_FIRST && idx_i <= PSS_W_REC_LAST) begin
      word_o = pending_rec_i[32*rec_sel +: 32];                 // R11
    end else if (idx_i >= PSS_W_CNT_FIRST && idx_i <= PSS_W_CNT_LAST) begin
      word_o = counters_i[PSS_CNT_W*cnt_sel +: PSS_CNT_W];      // R12
    end
  end

endmodule : pss_image_word
`default_nettype wire

// *** verilog/pss_pkg.sv ***
// Constants for the profiling state save image block
package pss_pkg;

  // Save region geometry within the extended-state save area
  localparam int unsigned PSS_REGION_BYTES    = 128;
  localparam int unsigned PSS_REGION_OFFSET   = 832;
  localparam int unsigned PSS_FEATURE_BIT     = 62;
  localparam int unsigned PSS_WORDS           = PSS_REGION_BYTES / 4;
  localparam int unsigned PSS_IDX_W           = 5;
  localparam int unsigned PSS_SAVE_ADDR_W     = 10;

  // Word indices of the image fields, four bytes per word
  localparam logic [4:0] PSS_W_CB_LO          = 5'h00;
  localparam logic [4:0] PSS_W_CB_HI          = 5'h01;
  localparam logic [4:0] PSS_W_FLAGS          = 5'h02;
  localparam logic [4:0] PSS_W_HEAD           = 5'h03;
  localparam logic [4:0] PSS_W_BASE_LO        = 5'h04;
  localparam logic [4:0] PSS_W_BASE_HI        = 5'h05;
  localparam logic [4:0] PSS_W_SIZE           = 5'h06;
  localparam logic [4:0] PSS_W_FILTER         = 5'h07;
  localparam logic [4:0] PSS_W_REC_FIRST      = 5'h08;
  localparam logic [4:0] PSS_W_REC_LAST       = 5'h0f;
  localparam logic [4:0] PSS_W_CNT_FIRST      = 5'h10;
  localparam logic [4:0] PSS_W_CNT_LAST       = 5'h15;
  localparam logic [4:0] PSS_W_LAST           = 5'h1f;

  // Field widths and positions
  localparam int unsigned PSS_EVENTS          = 6;
  localparam int unsigned PSS_FLAG_LSB        = 1;
  localparam int unsigned PSS_SIZE_W          = 28;
  localparam int unsigned PSS_REC_W           = 256;
  localparam int unsigned PSS_CNT_W           = 32;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] PSS_REG_FEAT_LO      = 8'h00;
  localparam logic [7:0] PSS_REG_FEAT_HI      = 8'h04;
  localparam logic [7:0] PSS_REG_ID_SIZE      = 8'h08;
  localparam logic [7:0] PSS_REG_ID_OFFSET    = 8'h0c;
  localparam logic [7:0] PSS_REG_STATUS       = 8'h10;
  localparam int unsigned PSS_FEAT_HI_BIT     = PSS_FEATURE_BIT - 32;
  localparam logic        PSS_FEAT_RESET      = 1'b0;
  localparam int unsigned PSS_ST_BUSY         = 0;
  localparam int unsigned PSS_ST_BITMAP       = 1;
  localparam int unsigned PSS_ST_SKIPPED      = 2;

  // AXI responses
  localparam logic [1:0] PSS_RESP_OKAY        = 2'h0;
  localparam logic [1:0] PSS_RESP_SLVERR      = 2'h2;

  // Save sequencer states
  typedef enum logic [1:0] {
    PSS_IDLE  = 2'b00,
    PSS_WRITE = 2'b01,
    PSS_DONE  = 2'b10
  } pss_state_t;

endpackage : pss_pkg

// *** verilog/pss_save_image.sv ***
// Profiling state save image sequencer with AXI4-Lite control registers
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01 - Feature enable bit 62 says profiling state can be saved, restored, used.
// R02 - Save region is 128 bytes starting 832 bytes into the save area.
// R03 - Region length and offset readable through identification query registers.
// R04 - Every reserved field of the region is written as zero.
// R05 - Bytes 7-0 hold control block address; zero means profiling disabled.
// R06 - Flag bit 0 reserved; bit 1 marks event 1 active with counter.
// R07 - Flag bits 6:2 mark events 2-6; higher flag bits reserved zero.
// R08 - Bytes 15-12 ring head offset; bytes 23-16 ring base address.
// R09 - Bits 27:0 at bytes 27-24 ring size; bits 31:28 reserved.
// R10 - Bytes 31-28 hold filter settings as in the control block.
// R11 - Bytes 63-32 hold pending event record; zero identifier means none.
// R12 - Counters at bytes 67-64 and 87-68; bytes 127-88 reserved zero.
// R13 - Disabled profiling: save stores nothing and clears bitmap bit 62.
// R14 - Enabled profiling: save copies raw values and sets bitmap bit 62.
// R15 - Restore with feature on but bitmap bit clear loads supplied defaults.
// R16 - Multi-byte fields are stored little-endian, low byte at low offset.
module pss_save_image
  import pss_pkg::*;
#(
  parameter int unsigned AXI_ADDR_W = 8
)(
  input  wire logic                            sys_clk_i,
  input  wire logic                            reset_n_i,
  input  wire logic                            ce_i,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0]           s_axi_awaddr_i,
  input  wire logic                            s_axi_awvalid_i,
  output logic                                 s_axi_awready_o,
  input  wire logic [31:0]                     s_axi_wdata_i,
  input  wire logic [3:0]                      s_axi_wstrb_i,
  input  wire logic                            s_axi_wvalid_i,
  output logic                                 s_axi_wready_o,
  output logic [1:0]                           s_axi_bresp_o,
  output logic                                 s_axi_bvalid_o,
  input  wire logic                            s_axi_bready_i,
  input  wire logic [AXI_ADDR_W-1:0]           s_axi_araddr_i,
  input  wire logic                            s_axi_arvalid_i,
  output logic                                 s_axi_arready_o,
  output logic [31:0]                          s_axi_rdata_o,
  output logic [1:0]                           s_axi_rresp_o,
  output logic                                 s_axi_rvalid_o,
  input  wire logic                            s_axi_rready_i,
  // Internal profiling state, held stable by the core during a save
  input  wire logic [63:0]                     cb_addr_i,
  input  wire logic [PSS_EVENTS-1:0]           active_flags_i,
  input  wire logic [31:0]                     head_offset_i,
  input  wire logic [63:0]                     ring_base_i,
  input  wire logic [PSS_SIZE_W-1:0]           ring_size_i,
  input  wire logic [31:0]                     filters_i,
  input  wire logic [PSS_REC_W-1:0]            pending_rec_i,
  input  wire logic [PSS_EVENTS*PSS_CNT_W-1:0] counters_i,
  // Save and restore instruction requests
  input  wire logic                            save_req_i,
  input  wire logic                            restore_req_i,
  input  wire logic                            restore_bitmap_bit_i,
  // Save area write port
  output logic                                 save_wr_valid_o,
  input  wire logic                            save_wr_ready_i,
  output logic [PSS_SAVE_ADDR_W-1:0]           save_wr_addr_o,
  output logic [31:0]                          save_wr_data_o,
  output logic                                 save_done_o,
  output logic                                 bitmap_bit_o,
  output logic                                 feature_enable_o,
  output logic                                 restore_defaults_o
);

  // Elaboration check: the offset decode reads address bits 7:2, so eight bits are needed
  if (AXI_ADDR_W < 8 || AXI_ADDR_W > 32) begin : g_bad_addr_w
    $error("AXI_ADDR_W out of range");
  end

  localparam logic [PSS_SAVE_ADDR_W-1:0] BASE_ADDR = PSS_SAVE_ADDR_W'(PSS_REGION_OFFSET);

  pss_state_t                  state_ff, nxt_state;
  logic [4:0]                  idx_ff, nxt_idx;
  logic                        valid_ff, nxt_valid;
  logic [PSS_SAVE_ADDR_W-1:0]  addr_ff, nxt_addr;
  logic [31:0]                 data_ff, nxt_data;
  logic                        done_ff, nxt_done;
  logic                        bitmap_ff, nxt_bitmap;
  logic                        skipped_ff, nxt_skipped;
  logic                        defaults_ff, nxt_defaults;
  logic                        feat_ff, nxt_feat;
  logic [31:0]                 word;
  logic [4:0]                  word_idx;
  logic                        beat_taken;

  // Index of the next word to be formatted
  assign word_idx   = (state_ff == PSS_IDLE) ? PSS_W_CB_LO : 5'(idx_ff + 5'h01);
  assign beat_taken = valid_ff && save_wr_ready_i;

  pss_image_word u_word (
    .idx_i          (word_idx),
    .cb_addr_i      (cb_addr_i),
    .active_flags_i (active_flags_i),
    .head_offset_i  (head_offset_i),
    .ring_base_i    (ring_base_i),
    .ring_size_i    (ring_size_i),
    .filters_i      (filters_i),
    .pending_rec_i  (pending_rec_i),
    .counters_i     (counters_i),
    .word_o         (word)
  );

  // Save sequencer: one 32-bit word per beat, lowest offset first
  always_comb begin
    nxt_state    = state_ff;
    nxt_idx      = idx_ff;
    nxt_valid    = valid_ff;
    nxt_addr     = addr_ff;
    nxt_data     = data_ff;
    nxt_done     = 1'b0;
    nxt_bitmap   = bitmap_ff;
    nxt_skipped  = skipped_ff;
    nxt_defaults = 1'b0;
    case (state_ff)
      PSS_IDLE: begin
        if (save_req_i) begin
          if (!feat_ff || cb_addr_i == 64'h0) begin             // R05
            nxt_state   = PSS_DONE;                             // R13
            nxt_bitmap  = 1'b0;                                 // R13
            nxt_skipped = 1'b1;
          end else begin
            nxt_state   = PSS_WRITE;                            // R14
            nxt_idx     = PSS_W_CB_LO;
            nxt_valid   = 1'b1;
            nxt_addr    = BASE_ADDR;                            // R02
            nxt_data    = word;                                 // R16
            nxt_skipped = 1'b0;
          end
        end else if (restore_req_i && feat_ff && !restore_bitmap_bit_i) begin
          nxt_defaults = 1'b1;                                  // R15
        end
      end
      PSS_WRITE: begin
        if (beat_taken) begin
          if (idx_ff == PSS_W_LAST) begin
            nxt_valid  = 1'b0;
            nxt_state  = PSS_DONE;
            nxt_bitmap = 1'b1;                                  // R14
          end else begin
            nxt_idx  = word_idx;
            nxt_addr = PSS_SAVE_ADDR_W'(addr_ff + 10'h004);     // R16
            nxt_data = word;
          end
        end
      end
      PSS_DONE: begin
        nxt_done  = 1'b1;
        nxt_state = PSS_IDLE;
      end
      default: begin
        nxt_state = PSS_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff    <= PSS_IDLE;
      idx_ff      <= 5'h00;
      valid_ff    <= 1'b0;
      addr_ff     <= '0;
      data_ff     <= 32'h0000_0000;
      done_ff     <= 1'b0;
      bitmap_ff   <= 1'b0;
      skipped_ff  <= 1'b0;
      defaults_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff    <= nxt_state;
      idx_ff      <= nxt_idx;
      valid_ff    <= nxt_valid;
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
      done_ff     <= nxt_done;
      bitmap_ff   <= nxt_bitmap;
      skipped_ff  <= nxt_skipped;
      defaults_ff <= nxt_defaults;
    end
  end

  assign save_wr_valid_o    = valid_ff;
  assign save_wr_addr_o     = addr_ff;
  assign save_wr_data_o     = data_ff;
  assign save_done_o        = done_ff;
  assign bitmap_bit_o       = bitmap_ff;
  assign restore_defaults_o = defaults_ff;
  assign feature_enable_o   = feat_ff;                          // R01

  // AXI4-Lite slave state
  logic                  aw_held_ff, nxt_aw_held;
  logic                  w_held_ff, nxt_w_held;
  logic [AXI_ADDR_W-1:0] waddr_ff, nxt_waddr;
  logic [31:0]           wdata_ff, nxt_wdata;
  logic [3:0]            wstrb_ff, nxt_wstrb;
  logic                  bvalid_ff, nxt_bvalid;
  logic [1:0]            bresp_ff, nxt_bresp;
  logic                  rvalid_ff, nxt_rvalid;
  logic [1:0]            rresp_ff, nxt_rresp;
  logic [31:0]           rdata_ff, nxt_rdata;
  logic [7:0]            rd_addr_ff, nxt_rd_addr;

  // Word-aligned register offset from a bus address
  function automatic logic [7:0] reg_off(input logic [AXI_ADDR_W-1:0] a);
    reg_off = {a[7:2], 2'b00};
  endfunction : reg_off

  // Writes take address and data in either order; reads answer next cycle
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_feat    = feat_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    nxt_rd_addr = rd_addr_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_held = 1'b1;
      nxt_waddr   = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata_i;
      nxt_wstrb  = s_axi_wstrb_i;
    end
    if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_held_ff && w_held_ff && !bvalid_ff) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = PSS_RESP_OKAY;
      if (reg_off(waddr_ff) == PSS_REG_FEAT_HI) begin
        if (wstrb_ff[3]) begin
          nxt_feat = wdata_ff[PSS_FEAT_HI_BIT];                 // R01
        end
      end else if (reg_off(waddr_ff) == PSS_REG_FEAT_LO || reg_off(waddr_ff) == PSS_REG_ID_SIZE ||
                   reg_off(waddr_ff) == PSS_REG_ID_OFFSET || reg_off(waddr_ff) == PSS_REG_STATUS) begin
        nxt_bresp = PSS_RESP_OKAY;
      end else begin
        nxt_bresp = PSS_RESP_SLVERR;
      end
    end
    if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid  = 1'b1;
      nxt_rresp   = PSS_RESP_OKAY;
      nxt_rdata   = 32'h0000_0000;
      nxt_rd_addr = reg_off(s_axi_araddr_i);
      if (reg_off(s_axi_araddr_i) == PSS_REG_FEAT_LO) begin
        nxt_rdata = 32'h0000_0000;
      end else if (reg_off(s_axi_araddr_i) == PSS_REG_FEAT_HI) begin
        nxt_rdata[PSS_FEAT_HI_BIT] = feat_ff;                   // R01
      end else if (reg_off(s_axi_araddr_i) == PSS_REG_ID_SIZE) begin
        nxt_rdata = 32'(PSS_REGION_BYTES);                      // R03
      end else if (reg_off(s_axi_araddr_i) == PSS_REG_ID_OFFSET) begin
        nxt_rdata = 32'(PSS_REGION_OFFSET);                     // R03
      end else if (reg_off(s_axi_araddr_i) == PSS_REG_STATUS) begin
        nxt_rdata[PSS_ST_BUSY]    = (state_ff != PSS_IDLE);
        nxt_rdata[PSS_ST_BITMAP]  = bitmap_ff;
        nxt_rdata[PSS_ST_SKIPPED] = skipped_ff;
      end else begin
        nxt_rresp = PSS_RESP_SLVERR;
      end
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= PSS_RESP_OKAY;
      feat_ff    <= PSS_FEAT_RESET;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= PSS_RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
      rd_addr_ff <= 8'h00;
    end else if (ce_i) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      feat_ff    <= nxt_feat;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      rd_addr_ff <= nxt_rd_addr;
    end
  end

  // Readies are combinational; frozen with the clock enable
  assign s_axi_awready_o = ce_i && !aw_held_ff;
  assign s_axi_wready_o  = ce_i && !w_held_ff;
  assign s_axi_arready_o = ce_i && !rvalid_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign s_axi_rdata_o   = rdata_ff;

  // Checks on the image and the control paths
  AST_SKIP_CLEARS_BIT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R13
    (state_ff == PSS_IDLE && save_req_i && cb_addr_i == 64'h0)
      |=> !save_wr_valid_o ##1 (save_done_o && !bitmap_bit_o))
    else $error("disabled save wrote data or left bitmap bit set");
  AST_SAVE_SETS_BIT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R14
    (beat_taken && idx_ff == PSS_W_LAST) |=> bitmap_bit_o ##1 save_done_o)
    else $error("full save did not set bitmap bit");
  AST_FIRST_OFFSET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R02
    $rose(save_wr_valid_o) |-> (save_wr_addr_o == BASE_ADDR && idx_ff == PSS_W_CB_LO))
    else $error("save did not start at region offset");
  AST_NEXT_WORD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R16
    (beat_taken && idx_ff != PSS_W_LAST) |=> (save_wr_valid_o && save_wr_addr_o == $past(save_wr_addr_o) + 10'h004))
    else $error("save words not in ascending order");
  AST_FLAG_RSVD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R07
    (save_wr_valid_o && idx_ff == PSS_W_FLAGS) |-> (save_wr_data_o[0] == 1'b0 && save_wr_data_o[31:7] == 25'h0))
    else $error("reserved flag bits not zero");
  AST_SIZE_RSVD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R09
    (save_wr_valid_o && idx_ff == PSS_W_SIZE) |-> save_wr_data_o[31:28] == 4'h0)
    else $error("reserved size bits not zero");
  AST_TAIL_RSVD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
    (save_wr_valid_o && idx_ff > PSS_W_CNT_LAST) |-> save_wr_data_o == 32'h0000_0000)
    else $error("reserved counter slot not zero");
  AST_RESTORE_DEF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R15
    (state_ff == PSS_IDLE && !save_req_i && restore_req_i && feat_ff && !restore_bitmap_bit_i)
      |=> restore_defaults_o ##1 !restore_defaults_o)
    else $error("restore defaults not signalled once");
  AST_ID_SIZE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R03
    ($rose(s_axi_rvalid_o) && rd_addr_ff == PSS_REG_ID_SIZE) |-> s_axi_rdata_o == 32'h0000_0080)
    else $error("identification size read wrong");
  AST_FEAT_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !ce_i) // R01
    (aw_held_ff && w_held_ff && !bvalid_ff && reg_off(waddr_ff) == PSS_REG_FEAT_HI && wstrb_ff[3])
      |=> (feature_enable_o == $past(wdata_ff[PSS_FEAT_HI_BIT]) && s_axi_bvalid_o))
    else $error("feature enable write not applied");

endmodule : pss_save_image
`default_nettype wire
